// >>> pkg/sfp_pkg.sv
// Purpose: Constants and types for the serial flash front end.
// Assumes: One 23-bit byte address space of 8M bytes behind the pins.
// Notes: Register offsets are byte addresses on the plain register port.
// Behaviour
// - 8M array: 256B pages, 4K sectors, 64K blocks
// - Serial clock modes 0 and 3 both work
// - Sample on rising edge, shift out on falling
// - Dual opcodes use IO0 and IO1 lanes
// - Quad opcodes use all four lanes
// - Quad commands run only with quad enable set
// - Pause works only while quad enable clear
// - Pause freezes the link, not internal work
// - Pause starts with select low, clock low
// - Pause ends on pause high, clock low
// - While paused outputs float, inputs ignored
// - Deselect while paused abandons the command
// - Set latch command sets the write latch
// - Listed commands and reset clear the latch
// - Protected region readable but never modified
// - Large region decode, top or bottom
// - Small region decode inside end blocks
// - Protect pin low freezes region and lock bits while quad enable clear
// - Deep power-down ignores all but wake, reset
// - Latch clear rejects writes, programs, erases
// - Program or erase into region is refused
// - Invert bit complements the protected region
// - Busy flag high during internal work
package sfp_pkg;

	// Array geometry; sizes, masks and limits in bytes.
	localparam int          ADDR_W       = 23;
	localparam int          PAGE_BYTES   = 256;
	localparam int          SECTOR_BYTES = 4096;
	localparam int          BLOCK_BYTES  = 65536;
	localparam int          SECTORS      = 2048;
	localparam int          BLOCKS       = 128;
	localparam logic [22:0] PAGE_MASK    = 23'h7fff00;
	localparam logic [22:0] SECT_MASK    = 23'h7ff000;
	localparam logic [22:0] HALF_MASK    = 23'h7f8000;
	localparam logic [22:0] BLK_MASK     = 23'h7f0000;
	localparam logic [23:0] ARRAY_TOP    = 24'h800000;
	localparam logic [23:0] BIG_UNIT     = 24'h020000;
	localparam logic [23:0] SMALL_UNIT   = 24'h001000;
	localparam logic [23:0] SMALL_MAX    = 24'h008000;

	// Opcodes.
	localparam logic [7:0] OP_SETWL  = 8'h06;
	localparam logic [7:0] OP_CLRWL  = 8'h04;
	localparam logic [7:0] OP_RDST   = 8'h05;
	localparam logic [7:0] OP_WRST   = 8'h01;
	localparam logic [7:0] OP_READ   = 8'h03;
	localparam logic [7:0] OP_FAST   = 8'h0b;
	localparam logic [7:0] OP_DOUT   = 8'h3b;
	localparam logic [7:0] OP_DIO    = 8'hbb;
	localparam logic [7:0] OP_DID    = 8'h92;
	localparam logic [7:0] OP_QOUT   = 8'h6b;
	localparam logic [7:0] OP_QIO    = 8'heb;
	localparam logic [7:0] OP_QWORD  = 8'he7;
	localparam logic [7:0] OP_QID    = 8'h94;
	localparam logic [7:0] OP_QPROG  = 8'h32;
	localparam logic [7:0] OP_PROG   = 8'h02;
	localparam logic [7:0] OP_SECT   = 8'h20;
	localparam logic [7:0] OP_HALF   = 8'h52;
	localparam logic [7:0] OP_BLOCK  = 8'hd8;
	localparam logic [7:0] OP_CHIP1  = 8'hc7;
	localparam logic [7:0] OP_CHIP2  = 8'h60;
	localparam logic [7:0] OP_SLEEP  = 8'hb9;
	localparam logic [7:0] OP_WAKE   = 8'hab;
	localparam logic [7:0] OP_RSTEN  = 8'h66;
	localparam logic [7:0] OP_RST    = 8'h99;

	// Bit counts at which command phases end, and the counter limits.
	localparam logic [5:0] OPC_END   = 6'h08;
	localparam logic [5:0] ST1_END   = 6'h10;
	localparam logic [5:0] ST2_END   = 6'h18;
	localparam logic [5:0] ADDR_END  = 6'h20;
	localparam logic [5:0] CNT_SAT   = 6'h3f;
	localparam logic [5:0] CNT_LIM   = 6'h3b;

	// Register offsets, control field positions, control reset value and busy default.
	localparam logic [3:0] REG_CTRL  = 4'h0;
	localparam logic [3:0] REG_STAT  = 4'h4;
	localparam logic [3:0] REG_FILL  = 4'h8;
	localparam logic [3:0] REG_LAST  = 4'hc;
	localparam int         CTRL_QE   = 0;
	localparam int         CTRL_RS   = 1;
	localparam int         CTRL_INV  = 6;
	localparam int         CTRL_LOCK = 7;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] BUSY_DEF = 16'h0040;

	typedef enum logic [2:0] {
		OPK_PROG,
		OPK_SECT,
		OPK_HALF,
		OPK_BLOCK,
		OPK_CHIP
	} sfp_opk_e;

	// Array operation handed to the array engine.
	typedef struct packed {
		logic        valid;
		sfp_opk_e    kind;
		logic [22:0] addr;
	} sfp_aop_s;

	// Whole state of the front end.
	typedef struct packed {
		logic        selN1, selN2, selN3;
		logic        ck1, ck2, ck3;
		logic [3:0]  io1, io2;
		logic        paused;
		logic [5:0]  bitCnt;
		logic [31:0] shreg;
		logic [7:0]  opc;
		logic [22:0] addr;
		logic [7:0]  outSh;
		logic        outOn;
		logic [3:0]  ioOut;
		logic [3:0]  ioOe;
		logic        write_latch;
		logic [15:0] busyCnt;
		logic        dpd;
		logic        rstArm;
		logic        qe;
		logic [4:0]  bp;
		logic        cmp;
		logic [1:0]  srp;
		logic [7:0]  fill;
		logic [7:0]  lastOpc;
		logic [31:0] rdata;
		sfp_aop_s    aop;
	} sfp_state_s;

endpackage : sfp_pkg

// >>> rtl/sfp_flash_front.sv
// Purpose: Pin-side command front end of a serial NOR flash.
// Assumes: sys_clk is far faster than the serial clock; pins are async.
// Notes: Commands take effect when select rises, as on the real part.
`timescale 1ns/1ps
`default_nettype none

module sfp_flash_front #(
	parameter logic [15:0] BUSY_CYCLES = sfp_pkg::BUSY_DEF
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic             devSelect_b,
	input  wire logic             serialClk,
	input  wire logic [3:0]       ioIn,
	output logic [3:0]            ioOut,
	output logic [3:0]            ioOe,
	input  wire logic [3:0]       regAddr,
	input  wire logic [31:0]      regWdata,
	input  wire logic             regWr,
	input  wire logic             regRd,
	output logic [31:0]           regRdata,
	output sfp_pkg::sfp_aop_s     arrayOp,
	output logic                  writeLatch,
	output logic                  busyFlag
);

	sfp_pkg::sfp_state_s s_q;
	sfp_pkg::sfp_state_s s_d;

	logic       ckRise, ckFall, selRise, active, quadOff, hwLock;
	logic       doExec, wantOut, hit;
	logic [2:0] wIn, wOut;
	logic [5:0] cntNext;
	logic [31:0] shNext;
	logic [7:0] src, v;
	logic [22:0] endAddr;

	// True for opcodes that move data over four lanes.
	function automatic logic isQuad(input logic [7:0] op);
		return op == sfp_pkg::OP_QOUT || op == sfp_pkg::OP_QIO ||
			op == sfp_pkg::OP_QWORD || op == sfp_pkg::OP_QID ||
			op == sfp_pkg::OP_QPROG;
	endfunction : isQuad

	// Lane count: input lanes when dir is 0, output lanes when 1.
	function automatic logic [2:0] lanes(input logic [7:0] op,
		input logic [5:0] cnt, input logic dir, input logic qe);
		logic [2:0] w;
		w = 3'h1;
		if (cnt < sfp_pkg::OPC_END) begin
			w = 3'h1;
		end else if (op == sfp_pkg::OP_DIO || op == sfp_pkg::OP_DID) begin
			w = 3'h2;
		end else if (op == sfp_pkg::OP_DOUT) begin
			w = dir ? 3'h2 : 3'h1;
		end else if (isQuad(op) && !qe) begin
			w = 3'h1;
		end else if (op == sfp_pkg::OP_QIO || op == sfp_pkg::OP_QWORD ||
			op == sfp_pkg::OP_QID) begin
			w = 3'h4;
		end else if (op == sfp_pkg::OP_QOUT) begin
			w = dir ? 3'h4 : 3'h1;
		end else if (op == sfp_pkg::OP_QPROG) begin
			w = (cnt >= sfp_pkg::ADDR_END) ? 3'h4 : 3'h1;
		end
		return w;
	endfunction : lanes

	// Protected-region decode for one byte address.
	function automatic logic protHit(input logic [22:0] a,
		input logic [4:0] bp, input logic cmp);
		logic [23:0] size;
		logic [23:0] a24;
		logic        h;
		size = '0;
		a24 = {1'b0, a};
		h = 1'b0;
		if (bp[2:0] == 3'h7) begin
			h = 1'b1;
		end else if (bp[2:0] != 3'h0) begin
			if (!bp[4]) begin
				size = sfp_pkg::BIG_UNIT << (bp[2:0] - 3'h1);
			end else if (bp[2]) begin
				size = sfp_pkg::SMALL_MAX;
			end else begin
				size = sfp_pkg::SMALL_UNIT << (bp[2:0] - 3'h1);
			end
			h = bp[3] ? (a24 < size)
				: (a24 >= (sfp_pkg::ARRAY_TOP - size));
		end
		return h ^ cmp;
	endfunction : protHit

	// Edge and phase decode from the synchronised pins.
	always_comb begin
		ckRise  = s_q.ck2 & ~s_q.ck3;
		ckFall  = ~s_q.ck2 & s_q.ck3;
		selRise = s_q.selN2 & ~s_q.selN3;
		active  = ~s_q.selN2 & ~s_q.paused;
		quadOff = isQuad(s_q.opc) & ~s_q.qe;
		hwLock  = ~s_q.qe & ~s_q.io2[2];
		wIn     = lanes(s_q.opc, s_q.bitCnt, 1'b0, s_q.qe);
		wOut    = lanes(s_q.opc, s_q.bitCnt, 1'b1, s_q.qe);
		doExec  = selRise & ~s_q.paused & ~quadOff &
			(s_q.bitCnt >= sfp_pkg::OPC_END);
		endAddr = s_q.addr;
		case (s_q.opc)
			sfp_pkg::OP_PROG, sfp_pkg::OP_QPROG:
				endAddr = s_q.addr | ~sfp_pkg::PAGE_MASK;
			sfp_pkg::OP_SECT:  endAddr = s_q.addr | ~sfp_pkg::SECT_MASK;
			sfp_pkg::OP_HALF:  endAddr = s_q.addr | ~sfp_pkg::HALF_MASK;
			sfp_pkg::OP_BLOCK: endAddr = s_q.addr | ~sfp_pkg::BLK_MASK;
			default:           endAddr = s_q.addr;
		endcase
		// Checking both ends catches a small region inside a block.
		hit = protHit(s_q.addr, s_q.bp, s_q.cmp) |
			protHit(endAddr, s_q.bp, s_q.cmp);
		wantOut = 1'b0;
		if (!quadOff && !s_q.dpd) begin
			case (s_q.opc)
				sfp_pkg::OP_RDST:
					wantOut = s_q.bitCnt >= sfp_pkg::OPC_END;
				sfp_pkg::OP_READ, sfp_pkg::OP_FAST, sfp_pkg::OP_DOUT,
				sfp_pkg::OP_DIO, sfp_pkg::OP_DID, sfp_pkg::OP_QOUT,
				sfp_pkg::OP_QIO, sfp_pkg::OP_QWORD, sfp_pkg::OP_QID:
					wantOut = s_q.bitCnt >= sfp_pkg::ADDR_END;
				default: wantOut = 1'b0;
			endcase
		end
		src = (s_q.opc == sfp_pkg::OP_RDST) ?
			{s_q.srp[0], s_q.bp, s_q.write_latch, busyFlag} : s_q.fill;
		cntNext = (s_q.bitCnt > sfp_pkg::CNT_LIM) ? sfp_pkg::CNT_SAT
			: s_q.bitCnt + {3'h0, wIn};
		case (wIn)
			3'h2:    shNext = {s_q.shreg[29:0], s_q.io2[1:0]};
			3'h4:    shNext = {s_q.shreg[27:0], s_q.io2};
			default: shNext = {s_q.shreg[30:0], s_q.io2[0]};
		endcase
		v = s_q.outOn ? s_q.outSh : src;
	end

	// Next-state logic for the whole front end.
	always_comb begin
		s_d = s_q;
		s_d.aop.valid = 1'b0;
		// Two-flop synchronisers; only stage two and later feed logic.
		s_d.selN1 = devSelect_b;
		s_d.selN2 = s_q.selN1;
		s_d.selN3 = s_q.selN2;
		s_d.ck1   = serialClk;
		s_d.ck2   = s_q.ck1;
		s_d.ck3   = s_q.ck2;
		s_d.io1   = ioIn;
		s_d.io2   = s_q.io1;

		// Pause tracks the pin only while the clock is low.
		if (s_q.selN2 || s_q.qe) begin
			s_d.paused = 1'b0;
		end else if (!s_q.ck2 && !s_q.io2[3]) begin
			s_d.paused = 1'b1;
		end else if (!s_q.ck2 && s_q.io2[3]) begin
			s_d.paused = 1'b0;
		end

		// Internal work counts down regardless of the link or pause.
		if (s_q.busyCnt != 16'h0) begin
			s_d.busyCnt = s_q.busyCnt - 16'h1;
		end

		// Input shifting on rising serial clock edges.
		if (active && ckRise) begin
			s_d.shreg  = shNext;
			s_d.bitCnt = cntNext;
			if (s_q.bitCnt < sfp_pkg::OPC_END &&
				cntNext == sfp_pkg::OPC_END) begin
				s_d.opc = shNext[7:0];
			end
			if (s_q.bitCnt < sfp_pkg::ADDR_END &&
				cntNext == sfp_pkg::ADDR_END) begin
				s_d.addr = shNext[22:0];
			end
		end

		// Output shifting on falling edges; the byte recirculates.
		if (!active) begin
			s_d.ioOe = 4'h0;
		end else if (ckFall && wantOut) begin
			s_d.outOn = 1'b1;
			case (wOut)
				3'h2: begin
					s_d.ioOut = {2'h0, v[7:6]};
					s_d.ioOe  = 4'h3;
					s_d.outSh = {v[5:0], v[7:6]};
				end
				3'h4: begin
					s_d.ioOut = v[7:4];
					s_d.ioOe  = 4'hf;
					s_d.outSh = {v[3:0], v[7:4]};
				end
				default: begin
					s_d.ioOut = {2'h0, v[7], 1'b0};
					s_d.ioOe  = 4'h2;
					s_d.outSh = {v[6:0], v[7]};
				end
			endcase
		end

		// Command execution when select rises after a full opcode.
		if (doExec) begin
			s_d.lastOpc = s_q.opc;
			s_d.rstArm  = 1'b0;
			if (s_q.dpd && s_q.opc != sfp_pkg::OP_WAKE &&
				s_q.opc != sfp_pkg::OP_RSTEN &&
				s_q.opc != sfp_pkg::OP_RST) begin
				s_d.lastOpc = s_q.lastOpc;
			end else begin
				case (s_q.opc)
					sfp_pkg::OP_SETWL: s_d.write_latch = 1'b1;
					sfp_pkg::OP_CLRWL: s_d.write_latch = 1'b0;
					sfp_pkg::OP_SLEEP: s_d.dpd = 1'b1;
					sfp_pkg::OP_WAKE:  s_d.dpd = 1'b0;
					sfp_pkg::OP_RSTEN: s_d.rstArm = 1'b1;
					sfp_pkg::OP_RST: begin
						if (s_q.rstArm) begin
							s_d.write_latch = 1'b0;
							s_d.dpd = 1'b0;
						end
					end
					sfp_pkg::OP_WRST: begin
						s_d.write_latch = 1'b0;
						if (s_q.write_latch && s_q.busyCnt == 16'h0 &&
							s_q.bitCnt >= sfp_pkg::ST1_END) begin
							s_d.busyCnt = BUSY_CYCLES;
							if (s_q.bitCnt == sfp_pkg::ST1_END) begin
								if (!hwLock) begin
									s_d.srp[0] = s_q.shreg[7];
									s_d.bp     = s_q.shreg[6:2];
								end
							end else begin
								if (!hwLock) begin
									s_d.srp = {s_q.shreg[0], s_q.shreg[15]};
									s_d.bp  = s_q.shreg[14:10];
								end
								s_d.qe  = s_q.shreg[1];
								s_d.cmp = s_q.shreg[6];
							end
						end
					end
					sfp_pkg::OP_PROG, sfp_pkg::OP_QPROG, sfp_pkg::OP_SECT,
					sfp_pkg::OP_HALF, sfp_pkg::OP_BLOCK: begin
						s_d.write_latch = 1'b0;
						if (s_q.write_latch && s_q.busyCnt == 16'h0 && !hit &&
							s_q.bitCnt >= sfp_pkg::ADDR_END) begin
							s_d.aop.valid = 1'b1;
							s_d.busyCnt   = BUSY_CYCLES;
							case (s_q.opc)
								sfp_pkg::OP_SECT: begin
									s_d.aop.kind = sfp_pkg::OPK_SECT;
									s_d.aop.addr = s_q.addr & sfp_pkg::SECT_MASK;
								end
								sfp_pkg::OP_HALF: begin
									s_d.aop.kind = sfp_pkg::OPK_HALF;
									s_d.aop.addr = s_q.addr & sfp_pkg::HALF_MASK;
								end
								sfp_pkg::OP_BLOCK: begin
									s_d.aop.kind = sfp_pkg::OPK_BLOCK;
									s_d.aop.addr = s_q.addr & sfp_pkg::BLK_MASK;
								end
								default: begin
									s_d.aop.kind = sfp_pkg::OPK_PROG;
									s_d.aop.addr = s_q.addr;
								end
							endcase
						end
					end
					sfp_pkg::OP_CHIP1, sfp_pkg::OP_CHIP2: begin
						s_d.write_latch = 1'b0;
						if (s_q.write_latch && s_q.busyCnt == 16'h0 &&
							((s_q.bp[2:0] == 3'h0 && !s_q.cmp) ||
							(s_q.bp[2:0] == 3'h7 && s_q.cmp))) begin
							s_d.aop.valid = 1'b1;
							s_d.aop.kind  = sfp_pkg::OPK_CHIP;
							s_d.aop.addr  = '0;
							s_d.busyCnt   = BUSY_CYCLES;
						end
					end
					default: s_d.lastOpc = s_q.opc;
				endcase
			end
		end

		// Deselect returns the serial interface to idle.
		if (s_q.selN2) begin
			s_d.bitCnt = '0;
			s_d.outOn  = 1'b0;
			s_d.ioOe   = 4'h0;
		end

		// Register port; read data appear the cycle after the strobe.
		s_d.rdata = '0;
		if (regWr) begin
			if (regAddr == sfp_pkg::REG_CTRL) begin
				s_d.qe  = regWdata[sfp_pkg::CTRL_QE];
				s_d.bp  = regWdata[sfp_pkg::CTRL_RS +: 5];
				s_d.cmp = regWdata[sfp_pkg::CTRL_INV];
				s_d.srp = regWdata[sfp_pkg::CTRL_LOCK +: 2];
			end else if (regAddr == sfp_pkg::REG_FILL) begin
				s_d.fill = regWdata[7:0];
			end
		end
		if (regRd) begin
			if (regAddr == sfp_pkg::REG_CTRL) begin
				s_d.rdata = {23'h0, s_q.srp, s_q.cmp, s_q.bp, s_q.qe};
			end else if (regAddr == sfp_pkg::REG_STAT) begin
				s_d.rdata = {26'h0, s_q.rstArm, s_q.dpd, s_q.paused,
					s_q.outOn, s_q.write_latch, busyFlag};
			end else if (regAddr == sfp_pkg::REG_FILL) begin
				s_d.rdata = {24'h0, s_q.fill};
			end else if (regAddr == sfp_pkg::REG_LAST) begin
				s_d.rdata = {24'h0, s_q.lastOpc};
			end
		end
	end

	// The single state register; reset loads constants only.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state flops; busyFlag decodes busyCnt.
	assign ioOut      = s_q.ioOut;
	assign ioOe       = s_q.ioOe;
	assign regRdata   = s_q.rdata;
	assign arrayOp    = s_q.aop;
	assign writeLatch = s_q.write_latch;
	assign busyFlag   = s_q.busyCnt != 16'h0;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_exec(logic [7:0] op);
		doExec && s_q.opc == op && !s_q.dpd;
	endsequence

	sequence s_progTry;
		doExec && (s_q.opc == sfp_pkg::OP_PROG ||
			s_q.opc == sfp_pkg::OP_SECT || s_q.opc == sfp_pkg::OP_BLOCK);
	endsequence

	property p_pauseQuiet;
		s_q.paused |=> ioOe == 4'h0;
	endproperty
	a_pauseQuiet: assert property (p_pauseQuiet)
		else $error("Lanes driven while paused.");

	property p_noPauseQuad;
		s_q.qe |=> !s_q.paused;
	endproperty
	a_noPauseQuad: assert property (p_noPauseQuad)
		else $error("Pause taken with quad enable set.");

	property p_pauseEntry;
		$rose(s_q.paused) |-> !$past(s_q.ck2) && !$past(s_q.selN2);
	endproperty
	a_pauseEntry: assert property (p_pauseEntry)
		else $error("Pause entered with clock high or deselected.");

	property p_deselAbort;
		s_q.selN2 && s_q.paused |=> !s_q.paused && s_q.bitCnt == 6'h0
			##1 !s_q.aop.valid;
	endproperty
	a_deselAbort: assert property (p_deselAbort)
		else $error("Paused command not abandoned on deselect.");

	property p_setLatch;
		s_exec(sfp_pkg::OP_SETWL) |=> s_q.write_latch;
	endproperty
	a_setLatch: assert property (p_setLatch)
		else $error("Write latch not set.");

	property p_clrLatch;
		s_exec(sfp_pkg::OP_CLRWL) |=> !s_q.write_latch;
	endproperty
	a_clrLatch: assert property (p_clrLatch)
		else $error("Write latch not cleared.");

	property p_latchGate;
		s_progTry and (!s_q.write_latch) |=> !s_q.aop.valid;
	endproperty
	a_latchGate: assert property (p_latchGate)
		else $error("Array operation issued without write latch.");

	property p_protect;
		s_progTry and (hit) |=> !s_q.aop.valid;
	endproperty
	a_protect: assert property (p_protect)
		else $error("Array operation issued into protected region.");

	property p_sleepIgnore;
		doExec && s_q.dpd && s_q.opc == sfp_pkg::OP_SETWL && !s_q.write_latch
			|=> !s_q.write_latch;
	endproperty
	a_sleepIgnore: assert property (p_sleepIgnore)
		else $error("Command obeyed in deep power-down.");

	property p_busy;
		s_q.aop.valid |-> busyFlag [*8];
	endproperty
	a_busy: assert property (p_busy)
		else $error("Busy flag dropped during internal work.");

endmodule : sfp_flash_front

`default_nettype wire

// >>> dv/sfp_host_model.sv
// Purpose: Host serial controller model that drives select, clock and lanes.
// Assumes: Half a serial clock period is sixteen sys_clk cycles (80 ns).
// Notes: An undriven IO1 reads as the inverse of its last level.
`timescale 1ns/1ps
`default_nettype none

module sfp_host_model (
	input  wire logic       sys_clk,
	output logic            devSelect_b,
	output logic            serialClk,
	output logic [3:0]      ioIn,
	input  wire logic [3:0] ioOut,
	input  wire logic [3:0] ioOe
);
	logic       dIo0;
	logic       protLvl;
	logic       holdLvl;
	logic [3:0] lastIo;
	int         halfCyc;

	// Device drive wins; a floating IO1 must never look like a held value.
	always_comb begin
		ioIn[0] = ioOe[0] ? ioOut[0] : dIo0;
		ioIn[1] = ioOe[1] ? ioOut[1] : ~lastIo[1];
		ioIn[2] = ioOe[2] ? ioOut[2] : protLvl;
		ioIn[3] = ioOe[3] ? ioOut[3] : holdLvl;
	end

	// Remember the last lane levels for the floating pattern.
	always @(posedge sys_clk) begin
		lastIo <= ioIn;
	end

	// Idle pins: deselected, pause released, protect pin high.
	initial begin
		devSelect_b = 1'b1;
		serialClk   = 1'b0;
		dIo0        = 1'b0;
		protLvl     = 1'b1;
		holdLvl     = 1'b1;
		lastIo      = 4'h0;
		halfCyc     = 16;
	end

	// The clock settles at its mode 0 or 3 idle level before select falls.
	task automatic open_frame(input logic m3);
		@(posedge sys_clk);
		serialClk   <= m3;
		repeat (halfCyc) @(posedge sys_clk);
		devSelect_b <= 1'b0;
		repeat (halfCyc) @(posedge sys_clk);
	endtask : open_frame

	// Bits go out MSB first, valid at the rising edge, and are read there.
	task automatic shift(input int nb, input logic [31:0] tx,
		output logic [31:0] rx);
		rx = 32'h0;
		for (int i = 0; i < nb; i++) begin
			serialClk <= 1'b0;
			dIo0      <= tx[31 - i];
			repeat (halfCyc) @(posedge sys_clk);
			rx         = {rx[30:0], ioIn[1]};
			serialClk <= 1'b1;
			repeat (halfCyc) @(posedge sys_clk);
		end
	endtask : shift

	// Deselect ends the command; the gap leaves time for it to act.
	task automatic close_frame(input logic m3);
		serialClk <= m3;
		repeat (halfCyc) @(posedge sys_clk);
		devSelect_b <= 1'b1;
		repeat (12) @(posedge sys_clk);
	endtask : close_frame

	// Pause is released before any new select by the callers.
	task automatic pins(input logic ck, input logic hold, input logic prot);
		@(posedge sys_clk);
		serialClk <= ck;
		holdLvl   <= hold;
		protLvl   <= prot;
	endtask : pins

endmodule : sfp_host_model
`default_nettype wire

// >>> dv/sfp_flash_front_test.sv
// Purpose: Self-checking bench for the serial flash front end.
// Assumes: Busy time shortened to 32 cycles; serial clock period 160 ns.
// Notes: Commands act at deselect, so checks follow the closing gap.
`timescale 1ns/1ps
`default_nettype none

module sfp_flash_front_test;
	logic              sys_clk;
	logic              rst_b;
	logic              devSelect_b;
	logic              serialClk;
	logic [3:0]        ioIn;
	logic [3:0]        ioOut;
	logic [3:0]        ioOe;
	logic [3:0]        regAddr;
	logic [31:0]       regWdata;
	logic              regWr;
	logic              regRd;
	logic [31:0]       regRdata;
	sfp_pkg::sfp_aop_s arrayOp;
	sfp_pkg::sfp_aop_s lastOp;
	logic              writeLatch;
	logic              busyFlag;
	logic [3:0]        oeSeen;
	logic [31:0]       rx;
	logic [31:0]       rv;
	logic [44:0]       prot [12];
	logic              w;
	logic              ok;
	logic [2:0]        k;
	logic [7:0]        ctl;
	logic [7:0]        op;
	logic [23:0]       ad;
	int                n_fail;
	int                checks_done;
	int                opSeen;
	int                nOp;

	sfp_flash_front #(.BUSY_CYCLES(16'h0020)) u_dut (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.devSelect_b(devSelect_b),
		.serialClk(serialClk),
		.ioIn(ioIn),
		.ioOut(ioOut),
		.ioOe(ioOe),
		.regAddr(regAddr),
		.regWdata(regWdata),
		.regWr(regWr),
		.regRd(regRd),
		.regRdata(regRdata),
		.arrayOp(arrayOp),
		.writeLatch(writeLatch),
		.busyFlag(busyFlag));

	sfp_host_model u_host (
		.sys_clk(sys_clk),
		.devSelect_b(devSelect_b),
		.serialClk(serialClk),
		.ioIn(ioIn),
		.ioOut(ioOut),
		.ioOe(ioOe));

	// A 5 ns clock.
	initial sys_clk = 1'b0;
	always #2.5 sys_clk = ~sys_clk;

	// Count array operations and gather every lane the device enables.
	always @(posedge sys_clk) begin
		if (arrayOp.valid === 1'b1) begin
			opSeen++;
			lastOp = arrayOp;
		end
		oeSeen = oeSeen | ioOe;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge sys_clk);
		regWr    <= 1'b0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe.
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge sys_clk);
		regRd   <= 1'b0;
		#1 d = regRdata;
	endtask : reg_rd

	task automatic cmd(input int nb, input logic [31:0] tx);
		u_host.open_frame(1'b0);
		u_host.shift(nb, tx, rx);
		u_host.close_frame(1'b0);
	endtask : cmd

	task automatic op8(input logic [7:0] o);
		cmd(8, {o, 24'h0});
	endtask : op8

	// A busy that never ends would block every later status write, program or erase.
	task automatic wait_idle();
		for (int i = 0; i < 200 && busyFlag !== 1'b0; i++) @(posedge sys_clk);
		if (busyFlag !== 1'b0) begin
			n_fail++;
			complete_run();
		end
	endtask : wait_idle

	// Hang guard.
	initial begin
		repeat (100000) @(posedge sys_clk);
		n_fail++;
		complete_run();
	end

	// Main sequence: reset, then one test after another.
	initial begin
		rst_b = 1'b0;
		regAddr = 4'h0;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		oeSeen = 4'h0;
		n_fail = 0;
		checks_done = 0;
		opSeen = 0;
		prot = '{
			{1'b0, 1'b0, 3'd0, 8'h00, sfp_pkg::OP_PROG, 24'h000000},
			{1'b1, 1'b0, 3'd0, 8'h02, sfp_pkg::OP_PROG, 24'h7e0000},
			{1'b1, 1'b1, 3'd0, 8'h02, sfp_pkg::OP_PROG, 24'h7dff00},
			{1'b1, 1'b0, 3'd1, 8'h12, sfp_pkg::OP_SECT, 24'h01f000},
			{1'b1, 1'b1, 3'd1, 8'h12, sfp_pkg::OP_SECT, 24'h020000},
			{1'b1, 1'b0, 3'd3, 8'h22, sfp_pkg::OP_BLOCK, 24'h7f0000},
			{1'b1, 1'b1, 3'd1, 8'h22, sfp_pkg::OP_SECT, 24'h7fe000},
			{1'b1, 1'b0, 3'd1, 8'h38, sfp_pkg::OP_SECT, 24'h007000},
			{1'b1, 1'b0, 3'd0, 8'h42, sfp_pkg::OP_PROG, 24'h000000},
			{1'b1, 1'b1, 3'd0, 8'h42, sfp_pkg::OP_PROG, 24'h7e0000},
			{1'b1, 1'b1, 3'd4, 8'h00, sfp_pkg::OP_CHIP1, 24'h000000},
			{1'b1, 1'b0, 3'd4, 8'h02, sfp_pkg::OP_CHIP1, 24'h000000}};
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (8) @(posedge sys_clk);
		reg_rd(sfp_pkg::REG_STAT, rv);
		check("status reset", rv, 32'h0);
		reg_wr(4'h2, 32'hffff_ffff);
		reg_rd(4'h2, rv);
		check("unmapped", rv, 32'h0);
		$display("test registers done");
		op8(sfp_pkg::OP_SETWL);
		check("latch set", 32'(writeLatch), 32'h1);
		u_host.open_frame(1'b1);
		u_host.shift(16, {sfp_pkg::OP_RDST, 24'h0}, rx);
		u_host.close_frame(1'b1);
		check("status byte", 32'(rx[7:0]), 32'h02);
		op8(sfp_pkg::OP_CLRWL);
		check("latch clear", 32'(writeLatch), 32'h0);
		$display("test latch done");
		// Each entry: latch set first, accepted, kind, control, op, address.
		for (int i = 0; i < 12; i++) begin
			{w, ok, k, ctl, op, ad} = prot[i];
			reg_wr(sfp_pkg::REG_CTRL, {24'h0, ctl});
			if (w) op8(sfp_pkg::OP_SETWL);
			nOp = opSeen;
			cmd((op == sfp_pkg::OP_CHIP1) ? 8 : 32, {op, ad});
			check("op taken", opSeen - nOp, 32'(ok));
			check("latch after op", 32'(writeLatch), 32'h0);
			if (ok) begin
				check("op kind", 32'(lastOp.kind), 32'(k));
				if (op != sfp_pkg::OP_CHIP1) begin
					check("op addr", 32'(lastOp.addr), 32'(ad[22:0]));
				end
				check("busy", 32'(busyFlag), 32'h1);
				wait_idle();
			end
		end
		$display("test protection done");
		reg_wr(sfp_pkg::REG_CTRL, 32'h0);
		for (int i = 0; i < 2; i++) begin
			u_host.pins(1'b0, 1'b1, i[0]);
			op8(sfp_pkg::OP_SETWL);
			cmd(16, {sfp_pkg::OP_WRST, 8'h14, 16'h0});
			wait_idle();
			reg_rd(sfp_pkg::REG_CTRL, rv);
			check("region write", rv, i ? 32'h0a : 32'h0);
		end
		$display("test protect pin done");
		for (int i = 0; i < 3; i++) begin
			reg_wr(sfp_pkg::REG_CTRL, {31'h0, i != 0});
			op = (i == 2) ? sfp_pkg::OP_DOUT : sfp_pkg::OP_QOUT;
			oeSeen = 4'h0;
			u_host.open_frame(1'b0);
			u_host.shift(32, {op, 24'h0}, rx);
			u_host.shift(8, 32'h0, rx);
			u_host.close_frame(1'b0);
			check("lanes", 32'(oeSeen), i == 0 ? 32'h0 : i == 1 ? 32'hf : 32'h3);
		end
		reg_wr(sfp_pkg::REG_CTRL, 32'h0);
		$display("test lanes done");
		op8(sfp_pkg::OP_SLEEP);
		reg_rd(sfp_pkg::REG_STAT, rv);
		check("asleep", 32'(rv[4]), 32'h1);
		op8(sfp_pkg::OP_SETWL);
		check("latch asleep", 32'(writeLatch), 32'h0);
		op8(sfp_pkg::OP_WAKE);
		reg_rd(sfp_pkg::REG_STAT, rv);
		check("woken", 32'(rv[4]), 32'h0);
		op8(sfp_pkg::OP_SLEEP);
		op8(sfp_pkg::OP_RSTEN);
		op8(sfp_pkg::OP_RST);
		reg_rd(sfp_pkg::REG_STAT, rv);
		check("awake", 32'(rv[4]), 32'h0);
		op8(sfp_pkg::OP_SETWL);
		op8(sfp_pkg::OP_RSTEN);
		op8(sfp_pkg::OP_RST);
		check("latch reset", 32'(writeLatch), 32'h0);
		$display("test power-down done");
		// Half an opcode, pause, ignored clocks, resume, second half.
		u_host.open_frame(1'b0);
		u_host.shift(4, {sfp_pkg::OP_SETWL, 24'h0}, rx);
		u_host.pins(1'b1, 1'b0, 1'b1);
		repeat (8) @(posedge sys_clk);
		reg_rd(sfp_pkg::REG_STAT, rv);
		check("pause deferred", 32'(rv[3]), 32'h0);
		u_host.pins(1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge sys_clk);
		reg_rd(sfp_pkg::REG_STAT, rv);
		check("paused", 32'(rv[3]), 32'h1);
		check("lanes off", 32'(ioOe), 32'h0);
		u_host.shift(8, 32'hffff_ffff, rx);
		u_host.pins(1'b1, 1'b1, 1'b1);
		repeat (8) @(posedge sys_clk);
		reg_rd(sfp_pkg::REG_STAT, rv);
		check("exit deferred", 32'(rv[3]), 32'h1);
		u_host.pins(1'b0, 1'b1, 1'b1);
		repeat (8) @(posedge sys_clk);
		reg_rd(sfp_pkg::REG_STAT, rv);
		check("resumed", 32'(rv[3]), 32'h0);
		u_host.shift(4, {sfp_pkg::OP_SETWL[3:0], 28'h0}, rx);
		u_host.close_frame(1'b0);
		check("latch after pause", 32'(writeLatch), 32'h1);
		u_host.open_frame(1'b0);
		u_host.shift(8, {sfp_pkg::OP_CLRWL, 24'h0}, rx);
		u_host.pins(1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge sys_clk);
		u_host.close_frame(1'b0);
		u_host.pins(1'b0, 1'b1, 1'b1);
		check("abandoned", 32'(writeLatch), 32'h1);
		reg_wr(sfp_pkg::REG_CTRL, 32'h1);
		u_host.open_frame(1'b0);
		u_host.shift(4, 32'h0, rx);
		u_host.pins(1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge sys_clk);
		reg_rd(sfp_pkg::REG_STAT, rv);
		check("no pause quad", 32'(rv[3]), 32'h0);
		u_host.pins(1'b0, 1'b1, 1'b1);
		u_host.close_frame(1'b0);
		$display("test pause done");
		complete_run();
	end

endmodule : sfp_flash_front_test
`default_nettype wire
